// ===== inc/usbef_defines.vh
`ifndef USBEF_DEFINES_VH
`define USBEF_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define USBEF_OFS_EVENT_FLAGS 8'h00
`define USBEF_OFS_EVENT_ENABLES 8'h04
`define USBEF_OFS_ERROR_FLAGS 8'h08
`define USBEF_OFS_ERROR_ENABLES 8'h0C
`define USBEF_OFS_STATUS_WINDOW 8'h10
`define USBEF_OFS_CONTROL 8'h14

// ----------------------------------------
// event flag and enable bit positions
// ----------------------------------------
`define USBEF_EV_STALL 7
`define USBEF_EV_ATTACH 6
`define USBEF_EV_RESUME 5
`define USBEF_EV_IDLE 4
`define USBEF_EV_TOKEN 3
`define USBEF_EV_SOF 2
`define USBEF_EV_ERROR 1
`define USBEF_EV_RESET 0

// ----------------------------------------
// error flag bit positions
// ----------------------------------------
`define USBEF_ER_STUFF 7
`define USBEF_ER_MATRIX 6
`define USBEF_ER_DMA 5
`define USBEF_ER_TURN 4
`define USBEF_ER_ALIGN 3
`define USBEF_ER_CRC16 2
`define USBEF_ER_CRC5 1
`define USBEF_ER_PID 0

// ----------------------------------------
// control register and status window
// ----------------------------------------
`define USBEF_CTL_HOST 0
`define USBEF_STAT_ENDP_HI 7
`define USBEF_STAT_ENDP_LO 4
`define USBEF_STAT_DIR 3
`define USBEF_STAT_PPBI 2

// ----------------------------------------
// reset values
// ----------------------------------------
`define USBEF_RST_BYTE 8'h00
`define USBEF_RST_WORD 32'h00000000

// ----------------------------------------
// timing
// ----------------------------------------
`define USBEF_CLK_PERIOD_PS 10000
`define USBEF_RESUME_TIME_PS 2500000
`define USBEF_ATTACH_TIME_PS 2500000
`define USBEF_IDLE_TIME_MS 3
`define USBEF_BIT_TIME_PS 83334
`define USBEF_TURN_BITS 16
`define USBEF_RESUME_CYCLES ((`USBEF_RESUME_TIME_PS + \
    `USBEF_CLK_PERIOD_PS - 1) / `USBEF_CLK_PERIOD_PS)
`define USBEF_ATTACH_CYCLES ((`USBEF_ATTACH_TIME_PS + \
    `USBEF_CLK_PERIOD_PS - 1) / `USBEF_CLK_PERIOD_PS)
`define USBEF_IDLE_CYCLES (`USBEF_IDLE_TIME_MS * \
    (1000000000 / `USBEF_CLK_PERIOD_PS))
`define USBEF_TURN_CYCLES ((`USBEF_TURN_BITS * `USBEF_BIT_TIME_PS + \
    `USBEF_CLK_PERIOD_PS - 1) / `USBEF_CLK_PERIOD_PS)

`endif

// ===== src/usbef_flags.v
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`include "usbef_defines.vh"

// Notes on behaviour
// - hardware-set flags except token done and error summary stay set until a one is written to them
// - stall flag: stall received as host, stall sent as device
// - attach: host role, 2.5 us without activity, bus not SE0
// - resume flag after K state held continuously for 2.5 us
// - idle flag after constant idle for 3 ms or longer
// - token done flag with status window; clearing pops status FIFO
// - frame start flag: SOF received as device, threshold as host
// - error summary read-only, set only by enabled error flags
// - flag bit 0: bus reset as device, detach as host
// - enable bits reset to zero, gate their matching flags
// - errors reach the interrupt only while enable bit 1 set
// - stuffing error flag on packet rejected for bit stuffing
// - matrix address error on bad descriptor table or buffer address
// - memory access error on late grant or truncating buffer
// - turnaround timeout after over sixteen idle bit times
// - byte alignment error on non-whole-byte data field
// - data checksum error on CRC16 failure
// - bit 1: CRC5 error as device, end-of-frame error as host
// - bits 31 to 8 read as zero
// - packet id error flag set when PID check fails
module usbef_flags #(
    parameter IDLE_CYCLES = `USBEF_IDLE_CYCLES
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    // line state from the transceiver
    input wire line_k_state,
    input wire line_se0,
    input wire line_idle,
    input wire bus_activity,
    // packet engine events as one-cycle pulses, plus token details and two levels
    input wire stall_received,
    input wire stall_sent,
    input wire token_complete,
    input wire [3:0] token_endpoint,
    input wire token_transmit,
    input wire token_odd_bank,
    input wire sof_received,
    input wire sof_threshold,
    input wire bus_reset_seen,
    input wire detach_seen,
    input wire stuffing_error,
    input wire matrix_address_error,
    input wire memory_access_error,
    input wire end_of_packet,
    input wire awaiting_reply,
    input wire byte_alignment_error,
    input wire data_checksum_error,
    input wire token_checksum_error,
    input wire transfer_active,
    input wire sof_counter_zero,
    input wire packet_id_error,
    // interrupt and role
    output wire module_interrupt_request,
    output wire host_role_enable
);

    // ----------------------------------------
    // register state
    // ----------------------------------------
    reg [7:0] event_flags;
    reg [7:0] event_enables;
    reg [7:0] error_flags;
    reg [7:0] error_enables;
    reg [7:0] control;
    reg data_phase;
    reg wr_phase;
    reg rd_wait;
    reg [7:0] phase_addr;

    wire [7:0] event_view;
    wire [7:0] status_view;
    wire error_summary_flag;
    wire addr_take;
    wire do_write;
    wire [7:0] wr_byte;

    function [7:0] usbef_read;
        input [7:0] ofs;
        input [7:0] ev;
        input [7:0] ee;
        input [7:0] er;
        input [7:0] eren;
        input [7:0] st;
        input [7:0] ct;
        begin
            case (ofs)
                `USBEF_OFS_EVENT_FLAGS: usbef_read = ev;
                `USBEF_OFS_EVENT_ENABLES: usbef_read = ee;
                `USBEF_OFS_ERROR_FLAGS: usbef_read = er;
                `USBEF_OFS_ERROR_ENABLES: usbef_read = eren;
                `USBEF_OFS_STATUS_WINDOW: usbef_read = st;
                `USBEF_OFS_CONTROL: usbef_read = ct;
                default: usbef_read = `USBEF_RST_BYTE;
            endcase
        end
    endfunction

    function usbef_hit;
        input [7:0] ofs;
        input [7:0] target;
        begin
            usbef_hit = (ofs == target);
        end
    endfunction

    assign host_role_enable = control[`USBEF_CTL_HOST];

    // ----------------------------------------
    // ahb-lite slave
    // ----------------------------------------
    // reads take one wait state so a read right after a write sees it
    assign hresp = 1'b0;
    assign hreadyout = ~rd_wait;
    assign addr_take = hsel & htrans[1] & hready;
    assign do_write = data_phase & wr_phase;
    assign wr_byte = hwdata[7:0];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_phase <= 1'b0;
            wr_phase <= 1'b0;
            rd_wait <= 1'b0;
            phase_addr <= 8'h00;
        end else begin
            if (rd_wait) begin
                rd_wait <= 1'b0;
                data_phase <= 1'b0;
            end else begin
                data_phase <= addr_take;
                wr_phase <= addr_take & hwrite;
                rd_wait <= addr_take & ~hwrite;
                if (addr_take) begin
                    phase_addr <= (haddr[31:8] == 24'h000000) ?
                        haddr[7:0] : 8'hFF;
                end
            end
        end
    end

    // upper bits are always zero
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= `USBEF_RST_WORD;
        end else if (rd_wait) begin
            hrdata <= {24'h000000, usbef_read(phase_addr, event_view,
                event_enables, error_flags, error_enables, status_view,
                control)};
        end
    end

    // ----------------------------------------
    // line-state timers
    // ----------------------------------------
    localparam [31:0] RESUME_FULL = `USBEF_RESUME_CYCLES;
    localparam [31:0] ATTACH_FULL = `USBEF_ATTACH_CYCLES;
    localparam [31:0] TURN_FULL = `USBEF_TURN_CYCLES;
    localparam [8:0] RESUME_CNT = RESUME_FULL[8:0];
    localparam [8:0] ATTACH_CNT = ATTACH_FULL[8:0];
    localparam [7:0] TURN_CNT = TURN_FULL[7:0];

    reg [8:0] resume_count;
    reg [8:0] attach_count;
    reg [18:0] idle_count;
    reg [7:0] turn_count;
    reg turn_armed;
    wire resume_hit;
    wire attach_hit;
    wire idle_hit;
    wire turn_hit;
    wire attach_ok;

    assign attach_ok = host_role_enable & ~bus_activity & ~line_se0;
    assign resume_hit = line_k_state &&
        (resume_count == RESUME_CNT - 9'd1);
    assign attach_hit = attach_ok &&
        (attach_count == ATTACH_CNT - 9'd1);
    assign idle_hit = line_idle && !bus_activity &&
        (idle_count == IDLE_CYCLES[18:0] - 19'd1);
    assign turn_hit = turn_armed && (turn_count == TURN_CNT);

    // resume, attach and idle timers saturate and the turnaround timer disarms, so each condition raises its flag once per episode
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            resume_count <= 9'h000;
            attach_count <= 9'h000;
            idle_count <= 19'h00000;
            turn_count <= 8'h00;
            turn_armed <= 1'b0;
        end else begin
            if (!line_k_state) begin
                resume_count <= 9'h000;
            end else if (resume_count != RESUME_CNT) begin
                resume_count <= resume_count + 9'd1;
            end
            if (!attach_ok) begin
                attach_count <= 9'h000;
            end else if (attach_count != ATTACH_CNT) begin
                attach_count <= attach_count + 9'd1;
            end
            if (!line_idle || bus_activity) begin
                idle_count <= 19'h00000;
            end else if (idle_count != IDLE_CYCLES[18:0]) begin
                idle_count <= idle_count + 19'd1;
            end
            if (end_of_packet) begin
                turn_armed <= awaiting_reply;
                turn_count <= 8'h00;
            end else if (bus_activity || !awaiting_reply || turn_hit) begin
                turn_armed <= 1'b0;
                turn_count <= 8'h00;
            end else if (turn_armed) begin
                turn_count <= turn_count + 8'd1;
            end
        end
    end

    // ----------------------------------------
    // token status fifo
    // ----------------------------------------
    // four entries; a completion arriving when full is dropped
    reg [5:0] stat_mem [0:3];
    reg [1:0] stat_rd;
    reg [1:0] stat_wr;
    reg [2:0] stat_count;
    wire stat_push;
    wire stat_pop;
    wire token_done_flag;

    assign token_done_flag = (stat_count != 3'd0);
    assign stat_pop = do_write && token_done_flag && wr_byte[`USBEF_EV_TOKEN]
        && usbef_hit(phase_addr, `USBEF_OFS_EVENT_FLAGS);
    assign stat_push = token_complete && (stat_count != 3'd4);
    assign status_view = token_done_flag ?
        {stat_mem[stat_rd], 2'b00} : `USBEF_RST_BYTE;

    always @(posedge hclk) begin
        if (stat_push) begin
            stat_mem[stat_wr] <= {token_endpoint, token_transmit,
                token_odd_bank};
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_rd <= 2'b00;
            stat_wr <= 2'b00;
            stat_count <= 3'd0;
        end else begin
            if (stat_push) begin
                stat_wr <= stat_wr + 2'd1;
            end
            if (stat_pop) begin
                stat_rd <= stat_rd + 2'd1;
            end
            case ({stat_push, stat_pop})
                2'b10: stat_count <= stat_count + 3'd1;
                2'b01: stat_count <= stat_count - 3'd1;
                default: stat_count <= stat_count;
            endcase
        end
    end

    // ----------------------------------------
    // event sources
    // ----------------------------------------
    wire [7:0] event_set;
    wire [7:0] error_set;
    wire [7:0] event_clr;
    wire [7:0] error_clr;

    assign event_set[`USBEF_EV_STALL] = host_role_enable ?
        stall_received : stall_sent;
    assign event_set[`USBEF_EV_ATTACH] = attach_hit;
    assign event_set[`USBEF_EV_RESUME] = resume_hit;
    assign event_set[`USBEF_EV_IDLE] = idle_hit;
    assign event_set[`USBEF_EV_TOKEN] = 1'b0;
    assign event_set[`USBEF_EV_SOF] = host_role_enable ?
        sof_threshold : sof_received;
    assign event_set[`USBEF_EV_ERROR] = 1'b0;
    assign event_set[`USBEF_EV_RESET] = host_role_enable ?
        detach_seen : bus_reset_seen;

    assign error_set[`USBEF_ER_STUFF] = stuffing_error;
    assign error_set[`USBEF_ER_MATRIX] = matrix_address_error;
    assign error_set[`USBEF_ER_DMA] = memory_access_error;
    assign error_set[`USBEF_ER_TURN] = turn_hit;
    assign error_set[`USBEF_ER_ALIGN] = byte_alignment_error;
    assign error_set[`USBEF_ER_CRC16] = data_checksum_error;
    assign error_set[`USBEF_ER_CRC5] = host_role_enable ?
        (transfer_active & sof_counter_zero) : token_checksum_error;
    assign error_set[`USBEF_ER_PID] = packet_id_error;

    assign event_clr = (do_write &&
        usbef_hit(phase_addr, `USBEF_OFS_EVENT_FLAGS)) ?
        wr_byte : `USBEF_RST_BYTE;
    assign error_clr = (do_write &&
        usbef_hit(phase_addr, `USBEF_OFS_ERROR_FLAGS)) ?
        wr_byte : `USBEF_RST_BYTE;

    // ----------------------------------------
    // sticky flags and enables
    // ----------------------------------------
    // a set in the same cycle as its clear wins
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    event_flags[gi] <= 1'b0;
                    error_flags[gi] <= 1'b0;
                end else begin
                    event_flags[gi] <= event_set[gi] |
                        (event_flags[gi] & ~event_clr[gi]);
                    error_flags[gi] <= error_set[gi] |
                        (error_flags[gi] & ~error_clr[gi]);
                end
            end
        end
    endgenerate

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_enables <= `USBEF_RST_BYTE;
            error_enables <= `USBEF_RST_BYTE;
            control <= `USBEF_RST_BYTE;
        end else if (do_write) begin
            if (usbef_hit(phase_addr, `USBEF_OFS_EVENT_ENABLES)) begin
                event_enables <= wr_byte;
            end
            if (usbef_hit(phase_addr, `USBEF_OFS_ERROR_ENABLES)) begin
                error_enables <= wr_byte;
            end
            if (usbef_hit(phase_addr, `USBEF_OFS_CONTROL)) begin
                control <= {7'h00, wr_byte[`USBEF_CTL_HOST]};
            end
        end
    end

    // ----------------------------------------
    // summary and interrupt request
    // ----------------------------------------
    // summary is derived, so writes to bit 1 have no effect
    assign error_summary_flag = |(error_flags & error_enables);

    assign event_view = {event_flags[7:4], token_done_flag,
        event_flags[`USBEF_EV_SOF], error_summary_flag,
        event_flags[`USBEF_EV_RESET]};

    // bit 1 of the mask gates all error flags
    assign module_interrupt_request =
        |(event_view & event_enables);

endmodule // usbef_flags

// ===== verification/usbef_flags_props.sv
// ------
// bus and interrupt checker
// ------
module usbef_props (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // bus
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    // interrupt and role
    input wire module_interrupt_request,
    input wire host_role_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    wire take = hsel && htrans[1] && hready;
    reg wr_ph;
    reg rd_ph;
    reg [31:0] ad;
    // one address register serves both: no new transfer inside a data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph <= 1'b0;
            rd_ph <= 1'b0;
            ad <= 32'h0;
        end else begin
            wr_ph <= take && hwrite;
            rd_ph <= (take && !hwrite) || (rd_ph && !hreadyout);
            ad <= take ? haddr : ad;
        end
    end
    hresp_okay_a: assert property (hresp == 1'b0)
        else $error("error response seen");
    read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    write_fast_a: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    upper_zero_a: assert property (hreadyout |-> hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    unmapped_zero_a: assert property (rd_ph && hreadyout && ad > 32'h14
        |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    role_hold_a: assert property (!(wr_ph && ad == 32'h14)
        |=> $stable(host_role_enable))
        else $error("role changed without write");
    irq_fall_a: assert property ($fell(module_interrupt_request) |-> $past(wr_ph))
        else $error("interrupt dropped without write");
    irq_reset_a: assert property ($rose(hresetn) |-> !module_interrupt_request)
        else $error("interrupt up after reset");
    cover property (take && !hwrite);
    cover property ($rose(module_interrupt_request));
    cover property ($fell(module_interrupt_request));
endmodule // usbef_props

bind usbef_flags usbef_props u_props (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
    .hreadyout, .hresp, .module_interrupt_request, .host_role_enable
);

// ===== verification/usbef_peer.sv
// ------
// usb peer and packet engine stand-in
// ------
module usbef_peer (
    // clock
    input wire hclk,
    // event pulses, line levels, token details
    output logic [15:0] pulse,
    output logic [5:0] lv,
    output logic [5:0] tok
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pulse = 16'h0000;
        lv = 6'h08; // bus busy holds idle, attach and turnaround timers; no K so resume stays off
        tok = 6'h00;
    end
    task automatic fire(input int i);
        @(posedge hclk);
        pulse[i] <= 1'b1;
        @(posedge hclk);
        pulse[i] <= 1'b0;
    endtask
    task automatic token(input logic [5:0] v);
        @(posedge hclk);
        tok <= v;
        pulse[2] <= 1'b1;
        @(posedge hclk);
        tok <= ~v; // details not held past the pulse
        pulse[2] <= 1'b0;
    endtask
    task automatic level(input int i, input logic v);
        @(posedge hclk);
        lv[i] <= v;
    endtask
    task automatic hold(input int i, input int n);
        level(i, 1'b1);
        repeat (n) @(posedge hclk);
        lv[i] <= 1'b0;
    endtask
endmodule // usbef_peer

// ===== verification/tb_top.sv
// ------
// flags and enables bench
// ------
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int IDLE_N = 20; // short idle count keeps the run brief
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b1;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, irq, host;
    wire [15:0] p;
    wire [5:0] lv, tok;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    always #5 hclk = ~hclk;
    usbef_flags #(.IDLE_CYCLES(IDLE_N)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .line_k_state(lv[0]), .line_se0(lv[1]),
        .line_idle(lv[2]), .bus_activity(lv[3]), .stall_received(p[0]),
        .stall_sent(p[1]), .token_complete(p[2]),
        .token_endpoint(tok[5:2]), .token_transmit(tok[1]),
        .token_odd_bank(tok[0]), .sof_received(p[3]),
        .sof_threshold(p[4]), .bus_reset_seen(p[5]), .detach_seen(p[6]),
        .stuffing_error(p[7]), .matrix_address_error(p[8]),
        .memory_access_error(p[9]), .end_of_packet(p[14]),
        .awaiting_reply(lv[4]), .byte_alignment_error(p[10]),
        .data_checksum_error(p[11]), .token_checksum_error(p[12]),
        .transfer_active(lv[5]), .sof_counter_zero(p[15]),
        .packet_id_error(p[13]), .module_interrupt_request(irq),
        .host_role_enable(host)
    );
    usbef_peer u_peer (.hclk(hclk), .pulse(p), .lv(lv), .tok(tok));
    // ------
    // bus and compare tasks
    // ------
    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= 1'b1;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic reg_is(input string what, input logic [31:0] a,
            input logic [31:0] exp);
        haddr <= a;
        hwrite <= 1'b0;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        check(what, hrdata, exp);
    endtask
    task automatic irq_is(input string what, input logic exp);
        @(posedge hclk);
        check(what, {31'h0, irq}, {31'h0, exp});
    endtask
    // ------
    // scenarios
    // ------
    task automatic t_reset();
        reg_is("flags", 32'h00, 32'h0);
        reg_is("enables", 32'h04, 32'h0);
        reg_is("errors", 32'h08, 32'h0);
        wr(32'h04, 32'hFFFFFFFF);
        reg_is("enable width", 32'h04, 32'hFF);
        hsel <= 1'b0;
        wr(32'h04, 32'h11);
        hsel <= 1'b1;
        reg_is("deselected", 32'h04, 32'hFF);
        wr(32'h104, 32'hFF);
        reg_is("unmapped", 32'h104, 32'h0);
        wr(32'h04, 32'hDF); // resume stays off outside suspend
    endtask
    task automatic t_events();
        u_peer.fire(1);
        u_peer.fire(3);
        u_peer.fire(5);
        u_peer.fire(4); // host source, ignored as device
        reg_is("device events", 32'h00, 32'h85);
        irq_is("irq", 1'b1);
        wr(32'h00, 32'h02);
        reg_is("zero write", 32'h00, 32'h85);
        wr(32'h04, 32'h5A);
        irq_is("masked irq", 1'b0);
        wr(32'h04, 32'hDF);
        wr(32'h00, 32'hFF);
        irq_is("irq off", 1'b0);
        wr(32'h14, 32'h1);
        @(posedge hclk);
        check("host role", {31'h0, host}, 32'h1);
        u_peer.fire(0);
        u_peer.fire(4);
        u_peer.fire(6);
        u_peer.fire(5); // device source, ignored as host
        reg_is("host events", 32'h00, 32'h85);
        wr(32'h00, 32'hFF);
        wr(32'h14, 32'h0);
        reg_is("cleared", 32'h00, 32'h0);
    endtask
    task automatic t_token();
        u_peer.token(6'h2B);
        u_peer.token(6'h16);
        reg_is("first entry", 32'h10, 32'hAC);
        wr(32'h00, 32'h08);
        reg_is("still done", 32'h00, 32'h08);
        reg_is("next entry", 32'h10, 32'h58);
        wr(32'h00, 32'h08);
        reg_is("fifo empty", 32'h00, 32'h0);
    endtask
    task automatic t_errors();
        int b;
        wr(32'h04, 32'h00); // error enable bit must start off
        for (b = 0; b < 8; b++) begin
            if (b != 4) begin
                u_peer.fire(b > 4 ? 14 - b : 13 - b);
                reg_is("error", 32'h08, 32'h1 << b);
                reg_is("summary off", 32'h00, 32'h0);
                wr(32'h0C, 32'h1 << b);
                reg_is("summary", 32'h00, 32'h02);
                irq_is("error gated", 1'b0);
                wr(32'h04, 32'h02);
                irq_is("error irq", 1'b1);
                wr(32'h08, 32'hFF);
                wr(32'h04, 32'h00);
            end
        end
        wr(32'h14, 32'h1);
        u_peer.fire(15);
        u_peer.level(5, 1'b1);
        u_peer.fire(15);
        u_peer.level(5, 1'b0);
        reg_is("frame end", 32'h08, 32'h02);
        wr(32'h08, 32'hFF);
        wr(32'h14, 32'h0);
    endtask
    task automatic t_timers();
        u_peer.hold(0, 249);
        reg_is("short k", 32'h00, 32'h0);
        u_peer.hold(0, 250);
        reg_is("resume", 32'h00, 32'h20);
        u_peer.level(3, 1'b0);
        u_peer.hold(2, IDLE_N - 1);
        reg_is("short idle", 32'h00, 32'h20);
        u_peer.hold(2, IDLE_N);
        reg_is("idle", 32'h00, 32'h30);
        u_peer.level(4, 1'b1);
        u_peer.fire(14);
        repeat (120) @(posedge hclk);
        u_peer.level(3, 1'b1);
        reg_is("no timeout", 32'h08, 32'h0);
        u_peer.level(3, 1'b0);
        u_peer.fire(14);
        repeat (150) @(posedge hclk);
        reg_is("timeout", 32'h08, 32'h10);
        u_peer.level(4, 1'b0);
        u_peer.level(1, 1'b1);
        wr(32'h14, 32'h1);
        wr(32'h00, 32'hFF);
        repeat (300) @(posedge hclk);
        reg_is("se0 no attach", 32'h00, 32'h0);
        u_peer.level(1, 1'b0);
        repeat (260) @(posedge hclk);
        reg_is("attach", 32'h00, 32'h40);
        u_peer.level(3, 1'b1);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            results();
        end
    end
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_events();
        t_token();
        t_errors();
        t_timers();
        results();
    end
endmodule // tb_top
